/* verilog/asrr_pkg.sv */
// Package of constants and types for the serial result readout block
package asrr_pkg;

  // Result format
  localparam int ASRR_RESULT_W = 16;
  localparam logic [15:0] ASRR_CODE_MID = 16'h8000;
  localparam logic [15:0] ASRR_CODE_MAX = 16'hffff;
  localparam logic [15:0] ASRR_CODE_MIN = 16'h0000;
  localparam logic [15:0] ASRR_RESULT_RST = 16'h0000;

  // Timing: system clock rate and documented times
  localparam int ASRR_CLK_HZ = 20000000;
  localparam int ASRR_CONV_TIME_US = 16600;
  localparam int ASRR_CONV_MAX_US = 23000;
  localparam int ASRR_POR_TIME_US = 500;
  localparam int ASRR_CONV_CYCLES = ASRR_CONV_TIME_US * (ASRR_CLK_HZ / 1000000);
  localparam int ASRR_POR_CYCLES = ASRR_POR_TIME_US * (ASRR_CLK_HZ / 1000000);
  localparam int ASRR_CNT_W = 24;

  // Analog sample handed in by the modulator model side
  typedef struct packed {
    logic signed [17:0] vin;
    logic [17:0] vref;
  } asrr_sample_t;

  // Top level states
  typedef enum logic [1:0] {
    ASRR_POR,
    ASRR_CONVERT,
    ASRR_SLEEP,
    ASRR_DATA_OUT
  } asrr_state_t;

  // Pin output group
  typedef struct packed {
    logic data;
    logic oe;
  } asrr_pin_t;

endpackage : asrr_pkg

/* verilog/asrr_sync.sv */
// Two flip-flop synchroniser with edge outputs
`timescale 1ns/1ps
module asrr_sync
  import asrr_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Async level in
  input wire logic i_async,
  // Synchronised level and edges
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Two stages, then one stage for edge detection
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign o_level = sync_reg;
  assign o_rise = sync_reg & ~prev_reg;
  assign o_fall = ~sync_reg & prev_reg;
endmodule : asrr_sync

/* verilog/asrr_core.sv */
// Conversion control and serial result readout of a 16-bit converter
`timescale 1ns/1ps
module asrr_core
  import asrr_pkg::*;
#(
  parameter int CONV_CYCLES = ASRR_CONV_CYCLES,
  parameter int POR_CYCLES = ASRR_POR_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Link pins from the host
  input wire logic i_sel_n,
  input wire logic i_sck,
  // Analog sample, link clock domain
  input wire logic i_link_clock,
  input wire asrr_sample_t i_sample,
  // Serial result pin
  output logic o_serial_result_out,
  output logic o_serial_result_out_oe,
  // Status
  output logic o_converting,
  output logic [15:0] o_last_result
);

  // Synchronised pins
  // Edge flags lag the pin by about two system clocks
  logic sel_n_lvl;
  logic sel_n_rise;
  logic sel_n_fall;
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;

  asrr_sync u_sel_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_sel_n),
    .o_level(sel_n_lvl),
    .o_rise(sel_n_rise),
    .o_fall(sel_n_fall)
  );

  asrr_sync u_sck_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_sck),
    .o_level(sck_lvl),
    .o_rise(sck_rise),
    .o_fall(sck_fall)
  );

  // Code computation in the link domain
  function automatic logic [15:0] asrr_code(input logic signed [17:0] vin,
                                            input logic [17:0] vref);
    logic signed [35:0] prod;
    logic signed [35:0] dvs;
    logic signed [35:0] quot;
    logic signed [36:0] code;
    prod = 36'(vin) * 36'sd32768;
    dvs = $signed({18'd0, vref});
    quot = 36'sd0;
    code = 37'sd0;
    if (vref == 18'd0) begin
      asrr_code = ASRR_CODE_MID;
    end else if (vin >= $signed({1'b0, vref[16:0]}) && vref[17] == 1'b0) begin
      asrr_code = ASRR_CODE_MAX;
    end else if (vin <= -$signed({1'b0, vref[16:0]}) && vref[17] == 1'b0) begin
      asrr_code = ASRR_CODE_MIN;
    end else begin
      quot = prod / dvs;
      // Division truncates toward zero; step down so small negatives keep sign clear
      if (prod < 36'sd0 && quot * dvs != prod) begin
        quot = quot - 36'sd1;
      end
      code = 37'(quot) + 37'sd32768;
      if (code > 37'sd65535) begin
        asrr_code = ASRR_CODE_MAX;
      end else if (code < 37'sd0) begin
        asrr_code = ASRR_CODE_MIN;
      end else begin
        asrr_code = code[15:0];
      end
    end
  endfunction : asrr_code

  // Busy states: power-on and conversion
  function automatic logic asrr_busy(input asrr_state_t st);
    asrr_busy = (st == ASRR_POR) || (st == ASRR_CONVERT);
  endfunction : asrr_busy

  // Link domain: code registered and held
  logic [15:0] link_code_reg;
  logic [15:0] link_hold_reg;
  logic link_req_meta_reg;
  logic link_req_sync_reg;
  logic link_req_prev_reg;
  logic link_ack_reg;

  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      link_code_reg <= ASRR_RESULT_RST;
    end else begin
      link_code_reg <= asrr_code(i_sample.vin, i_sample.vref);
    end
  end

  // Link domain: request toggle synchronised, then its edge found
  logic req_toggle_reg;
  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      link_req_meta_reg <= 1'b0;
      link_req_sync_reg <= 1'b0;
      link_req_prev_reg <= 1'b0;
    end else begin
      link_req_meta_reg <= req_toggle_reg;
      link_req_sync_reg <= link_req_meta_reg;
      link_req_prev_reg <= link_req_sync_reg;
    end
  end

  // Link domain: code captured and acknowledged on a request edge
  // Held code is read by the system side only after the ack returns
  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      link_hold_reg <= ASRR_RESULT_RST;
      link_ack_reg <= 1'b0;
    end else if (link_req_sync_reg != link_req_prev_reg) begin
      link_hold_reg <= link_code_reg;
      link_ack_reg <= link_req_sync_reg;
    end
  end

  // Ack back into system domain
  // Toggle protocol: one change per result, so no event is lost
  logic ack_meta_reg;
  logic ack_sync_reg;
  logic ack_prev_reg;
  logic ack_event;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
      ack_prev_reg <= 1'b0;
    end else begin
      ack_meta_reg <= link_ack_reg;
      ack_sync_reg <= ack_meta_reg;
      ack_prev_reg <= ack_sync_reg;
    end
  end
  assign ack_event = ack_sync_reg ^ ack_prev_reg;

  // State, counters and shift register
  asrr_state_t state_reg;
  asrr_state_t state_next;
  logic [ASRR_CNT_W-1:0] cnt_reg;
  logic [15:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic conv_done_reg;
  logic wait_ack_reg;

  // End of data output and start of next conversion
  // Select rise checked first; either ends the transfer the same way
  logic start_conv;
  always_comb begin
    start_conv = 1'b0;
    if (state_reg == ASRR_DATA_OUT) begin
      if (sel_n_rise) begin
        start_conv = 1'b1;
      end else if (sck_fall && bit_cnt_reg == 5'd15) begin
        start_conv = 1'b1;
      end
    end
  end

  // Next state
  // Sleep exit waits for both pins low, so idle-high needs a clock fall
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ASRR_POR: begin
        if (cnt_reg == ASRR_CNT_W'(POR_CYCLES - 1)) begin
          state_next = ASRR_CONVERT;
        end
      end
      ASRR_CONVERT: begin
        if (conv_done_reg) begin
          state_next = ASRR_SLEEP; // clock activity ignored here
        end
      end
      ASRR_SLEEP: begin
        if (!sel_n_lvl && !sck_lvl) begin
          state_next = ASRR_DATA_OUT;
        end
      end
      ASRR_DATA_OUT: begin
        if (start_conv) begin
          state_next = ASRR_CONVERT;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ASRR_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // Power-on and conversion timer
  // Keeps running through the handshake, far short of its wrap
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      cnt_reg <= '0;
    end else if (state_reg == ASRR_POR || state_reg == ASRR_CONVERT) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Request result at end of conversion, wait for handshake
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      req_toggle_reg <= 1'b0;
      wait_ack_reg <= 1'b0;
      conv_done_reg <= 1'b0;
    end else begin
      conv_done_reg <= 1'b0;
      if (state_reg == ASRR_CONVERT && !wait_ack_reg && !conv_done_reg &&
          cnt_reg == ASRR_CNT_W'(CONV_CYCLES - 1)) begin
        req_toggle_reg <= ~req_toggle_reg;
        wait_ack_reg <= 1'b1;
      end else if (wait_ack_reg && ack_event) begin
        wait_ack_reg <= 1'b0;
        conv_done_reg <= 1'b1;
      end
    end
  end

  // Result load and shift, MSB first
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      shift_reg <= ASRR_RESULT_RST;
    end else if (conv_done_reg) begin
      shift_reg <= link_hold_reg;
    end else if (state_reg == ASRR_DATA_OUT && !start_conv && sck_fall) begin
      shift_reg <= {shift_reg[14:0], 1'b0};
    end
  end

  // Bits shifted since the data output state began
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_reg <= 5'd0;
    end else if (conv_done_reg) begin
      bit_cnt_reg <= 5'd0;
    end else if (state_reg == ASRR_DATA_OUT) begin
      if (start_conv) begin
        bit_cnt_reg <= 5'd0;
      end else if (sck_fall) begin
        bit_cnt_reg <= bit_cnt_reg + 5'd1;
      end
    end
  end

  // Last loaded result
  // Kept for status; the shift register is consumed by readout
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_last_result <= ASRR_RESULT_RST;
    end else if (conv_done_reg) begin
      o_last_result <= link_hold_reg;
    end
  end

  // Busy flag, high through power-on and conversion
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_converting <= 1'b1;
    end else begin
      o_converting <= asrr_busy(state_next);
    end
  end

  // Output enable follows the synchronised select
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_serial_result_out_oe <= 1'b0;
    end else begin
      o_serial_result_out_oe <= ~sel_n_lvl;
    end
  end

  // Serial data bit, registered
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_serial_result_out <= 1'b0;
    end else begin
      unique case (state_next)
        ASRR_DATA_OUT: begin
          if (state_reg == ASRR_DATA_OUT && sck_fall) begin
            o_serial_result_out <= shift_reg[14];
          end else begin
            o_serial_result_out <= shift_reg[15];
          end
        end
        ASRR_SLEEP: o_serial_result_out <= 1'b0;
        ASRR_POR, ASRR_CONVERT: o_serial_result_out <= 1'b1;
      endcase
    end
  end

endmodule : asrr_core

/* test/asrr_core_properties.sv */
// Checker of readout pin and conversion timing
`timescale 1ns/1ps
module asrr_core_properties #(
  parameter int CONV_CYCLES = 200,
  parameter int POR_CYCLES = 20
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Pins and status
  input wire logic i_sel_n,
  input wire logic i_sck,
  input wire logic o_serial_result_out,
  input wire logic o_serial_result_out_oe,
  input wire logic o_converting,
  input wire logic [15:0] o_last_result
);
  int busy_reg;
  int quiet_reg;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // Conversion length and cycles since a pin moved
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      busy_reg <= 0;
      quiet_reg <= 0;
    end else begin
      busy_reg <= o_converting ? busy_reg + 1 : 0;
      quiet_reg <= ($changed(i_sck) || $changed(i_sel_n)) ? 0 : quiet_reg + int'(quiet_reg < 99);
    end
  end
  a_oe_released: assert property (i_sel_n [*6] |-> !o_serial_result_out_oe)
    else $error("output driven while deselected");
  a_oe_driven: assert property (!i_sel_n [*6] |-> o_serial_result_out_oe)
    else $error("output released while selected");
  a_busy_high: assert property ((o_converting && o_serial_result_out_oe) [*3] |->
    o_serial_result_out) else $error("busy not shown");
  a_conv_min_len: assert property ($fell(o_converting) |-> busy_reg >= CONV_CYCLES)
    else $error("conversion ended early");
  a_conv_max_len: assert property (busy_reg <= POR_CYCLES + CONV_CYCLES + 40)
    else $error("conversion overran");
  a_conv_holds: assert property ($rose(o_converting) |=> o_converting [*8])
    else $error("conversion dropped");
  a_data_steady: assert property ((quiet_reg > 8 && !o_converting) [*6] |=>
    $stable(o_serial_result_out)) else $error("data moved without a pin edge");
  a_result_at_end: assert property ($changed(o_last_result) |-> ##[0:30] !o_converting)
    else $error("result loaded mid conversion");
  c_clock_start: cover property ($rose(o_converting) && !i_sel_n);
  c_select_start: cover property ($rose(o_converting) && i_sel_n);
  c_conv_done: cover property ($fell(o_converting));
endmodule : asrr_core_properties

bind asrr_core asrr_core_properties #(.CONV_CYCLES(CONV_CYCLES), .POR_CYCLES(POR_CYCLES))
  u_props (.i_clock(i_clock), .i_rst(i_rst), .i_sel_n(i_sel_n), .i_sck(i_sck),
  .o_serial_result_out(o_serial_result_out), .o_serial_result_out_oe(o_serial_result_out_oe),
  .o_converting(o_converting), .o_last_result(o_last_result));

/* test/asrr_host.sv */
// Host model pacing select and serial clock
`timescale 1ns/1ps
module asrr_host (
  // Pacing clock and sensed wire
  input wire logic i_clock,
  input wire logic i_line,
  // Pins toward the device
  output logic o_sel_n,
  output logic o_sck
);
  localparam int HALF = 8;
  logic [15:0] word;
  // Idle: deselected, clock high
  initial begin
    o_sel_n = 1'b1;
    o_sck = 1'b1;
    word = 16'h0000;
  end
  // Hold a clock level for a half period
  task automatic half(input logic v);
    o_sck <= v;
    repeat (HALF) @(posedge i_clock);
  endtask : half
  // Select level, kept across the transfer
  task automatic sel(input logic v);
    o_sel_n <= v;
    repeat (HALF) @(posedge i_clock);
  endtask : sel
  // One pulse; bit taken as the clock rises
  task automatic pulse();
    if (o_sck) half(1'b0);
    word = {word[14:0], i_line};
    half(1'b1);
  endtask : pulse
endmodule : asrr_host

/* test/test_adc_serial_result_readout.sv */
// Self-checking bench of the serial result readout
`timescale 1ns/1ps
module test_adc_serial_result_readout;
  import asrr_pkg::*;
  typedef struct packed {
    logic [17:0] vin;
    logic [17:0] vref;
    logic [15:0] code;
    logic clock_idle_polarity;
    logic by_clock;
  } asrr_row_t;
  asrr_row_t rows [9] = '{
    '{18'h003e8, 18'h003e8, 16'hffff, 1'b1, 1'b1},
    '{18'h007d0, 18'h003e8, 16'hffff, 1'b1, 1'b0},
    '{18'h001f4, 18'h003e8, 16'hc000, 1'b0, 1'b1},
    '{18'h00000, 18'h003e8, 16'h8000, 1'b0, 1'b0},
    '{18'h3ffff, 18'h003e8, 16'h7fdf, 1'b0, 1'b1},
    '{18'h3fe0c, 18'h003e8, 16'h4000, 1'b1, 1'b1},
    '{18'h3fc18, 18'h003e8, 16'h0000, 1'b1, 1'b0},
    '{18'h3f448, 18'h003e8, 16'h0000, 1'b0, 1'b0},
    '{18'h3ffff, 18'h09c40, 16'h7fff, 1'b1, 1'b0}};
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic last_q = 1'b0;
  asrr_sample_t want = '0;
  asrr_sample_t sample = '0;
  logic sel_n, sck, data, oe, conv;
  logic [15:0] last;
  wire logic line;
  int mismatches = 0;
  int total_checks = 0;
  // System clock and unrelated sample clock
  initial forever #25 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // Sample crosses on its own clock; a released line shows the inverse
  always @(posedge link_clk) sample <= want;
  always @(posedge clk) if (oe === 1'b1) last_q <= data;
  assign line = (oe === 1'b1) ? data : ~last_q;
  asrr_core #(.CONV_CYCLES(200), .POR_CYCLES(20)) dut (.i_clock(clk), .i_rst(rst),
    .i_sel_n(sel_n), .i_sck(sck), .i_link_clock(link_clk), .i_sample(sample),
    .o_serial_result_out(data), .o_serial_result_out_oe(oe), .o_converting(conv),
    .o_last_result(last));
  asrr_host host (.i_clock(clk), .i_line(line), .o_sel_n(sel_n), .o_sck(sck));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  // Bounded wait for the busy flag
  task automatic wait_conv(input logic v, input int lim);
    int n;
    n = 0;
    while (conv !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (conv !== v) begin
      check(conv, v);
      finish_test();
    end
  endtask : wait_conv
  // One conversion and readout; next sample set before the trigger
  task automatic read_row(input asrr_row_t r, input asrr_row_t nx, input bit keep);
    host.half(r.clock_idle_polarity);
    if (r.clock_idle_polarity) host.sel(1'b0);
    if (r.clock_idle_polarity) check(line, 1'b1);
    wait_conv(1'b0, 2000);
    repeat (8) @(posedge clk);
    if (r.clock_idle_polarity) check(line, 1'b0);
    host.sel(1'b0);
    if (!r.clock_idle_polarity) check(line, r.code[15]);
    repeat (16) host.pulse();
    check(host.word, r.code);
    check(last, r.code);
    want = {nx.vin, nx.vref};
    if (r.by_clock) host.half(1'b0);
    else host.sel(1'b1);
    wait_conv(1'b1, 20);
    host.half(r.clock_idle_polarity);
    if (!keep) host.sel(1'b1);
  endtask : read_row
  // Reset, table rows, then abort, select-only and two-wire cases
  initial begin
    want = {rows[0].vin, rows[0].vref};
    repeat (16) @(posedge clk);
    check(conv, 1'b1);
    check(oe, 1'b0);
    check(last, 16'h0000);
    rst <= 1'b0;
    $display("Reset test done");
    foreach (rows[i]) begin
      read_row(rows[i], rows[(i + 1) % 9], 1'b0);
      $display("Row %0d done", i);
    end
    host.half(1'b1);
    wait_conv(1'b0, 2000);
    host.sel(1'b0);
    repeat (5) host.pulse();
    want = {rows[2].vin, rows[2].vref};
    host.sel(1'b1);
    check(oe, 1'b0);
    wait_conv(1'b1, 20);
    repeat (3) host.pulse();
    read_row(rows[2], rows[0], 1'b0);
    $display("Abort test done");
    wait_conv(1'b0, 2000);
    host.sel(1'b0);
    check(line, 1'b1);
    want = {rows[4].vin, rows[4].vref};
    host.sel(1'b1);
    wait_conv(1'b1, 20);
    $display("Select only test done");
    host.sel(1'b0);
    read_row(rows[4], rows[5], 1'b1);
    read_row(rows[5], rows[0], 1'b1);
    $display("Two wire test done");
    finish_test();
  end
endmodule : test_adc_serial_result_readout
